// ### hw/ccs_map.vh
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCS_ADDR_CLK_OP_MODE 3'h0
`define CCS_ADDR_MAIN_OSC_CTRL 3'h1
`define CCS_ADDR_MAIN_CLK_MODE 3'h2
`define CCS_ADDR_PROC_CLK_CTRL 3'h3
`define CCS_ADDR_INT_OSC_MODE 3'h4
`define CCS_ADDR_OSC_STAB 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCS_BIT_MAIN_EXT 7
`define CCS_BIT_MAIN_PIN 6
`define CCS_BIT_SUB_EXT 5
`define CCS_BIT_SUB_PIN 4
`define CCS_BIT_AMP_HIGH 0
`define CCS_BIT_MAIN_HALT 7
`define CCS_BIT_HS_SRC 2
`define CCS_BIT_MAIN_SYS 0
`define CCS_BIT_SUB_ALT 6
`define CCS_BIT_CPU_SUB 4
`define CCS_BIT_INT_STAT 7
`define CCS_BIT_INT_HALT 0
`define CCS_BIT_STAB_DONE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCS_RST_CLK_OP_MODE 8'h00
`define CCS_RST_MAIN_OSC_CTRL 8'h80
`define CCS_RST_MAIN_CLK_MODE 8'h00
`define CCS_RST_PROC_CLK_CTRL 8'h00
`define CCS_RST_INT_HALT 1'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCS_CLK_PERIOD_NS 4
`define CCS_AMP_HOLD_MIN_NS 4060
`define CCS_AMP_HOLD_CYC ((`CCS_AMP_HOLD_MIN_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`define CCS_AMP_HOLD_EXT_CLKS 160
`define CCS_OSTAB_CYC 1024
`define CCS_SW_GAP_CYC 2
`define CCS_CNT_W 11

// ----------------------------------------
// CPU source codes
// ----------------------------------------
`define CCS_SRC_INT 3'h1
`define CCS_SRC_HIGH 3'h2
`define CCS_SRC_SUB 3'h4

`endif

// ### hw/ccs_switch.v
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Crystal 1-10 MHz: setup, poll counter, select
// [RULE2] External main clock: no counter wait needed
// [RULE3] Crystal above 10 MHz: set high range
// [RULE4] External above 10 MHz: set high range
// [RULE5] Range and source bits change once only
// [RULE6] Setup steps skippable when already set
// [RULE7] Sub crystal: setup, wait stable, select sub
// [RULE8] External sub clock: setup, select, no wait
// [RULE9] Skip sub setup when already on sub
// [RULE10] Back to internal: restart, check status, deselect
// [RULE11] Skip internal restart when already internal
// [RULE12] Sub to internal: restart, check, clear selects
// [RULE13] Mode register bits 7-4 and 0
// [RULE14] Main halt in control bit 7
// [RULE15] Source bit 2, system select bit 0
// [RULE16] Sub start bit 6, CPU sub bit 4
// [RULE17] Internal status bit 7, halt bit 0
// [RULE18] Crystal high range: hold CPU clock 4.06us+
// [RULE19] External high range: hold 160 clocks
// [RULE20] Switch sources without truncated pulses
`include "ccs_map.vh"
module ccs_switch (
  input wire clk_sys,          // System clock
  input wire nrst,             // Sync reset, active low
  input wire [2:0] reg_addr,   // Register address
  input wire [7:0] reg_wdata,  // Write data
  input wire reg_wr,           // Write strobe
  input wire reg_rd,           // Read strobe
  output reg [7:0] reg_rdata,  // Read data, cycle after strobe
  input wire int_osc_ready,    // Internal oscillator running
  input wire sub_osc_ready,    // Subsystem oscillator stable
  input wire ext_main_tick,    // One pulse per external main clock
  output reg main_osc_en,      // Main crystal amplifier on
  output reg main_ext_en,      // Main external clock input on
  output reg main_amp_high,    // Main amplifier high range
  output reg sub_osc_en,       // Sub crystal amplifier on
  output reg sub_ext_en,       // Sub external clock input on
  output reg int_osc_en,       // Internal oscillator on
  output reg [2:0] cpu_src,    // CPU source, one-hot
  output reg cpu_clk_en        // CPU clock gate open
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam ST_RUN = 3'h1;
  localparam ST_OFF = 3'h2;
  localparam ST_ON = 3'h4;
  localparam integer AMP_CYC_N = `CCS_AMP_HOLD_CYC;
  localparam integer AMP_EXT_N = `CCS_AMP_HOLD_EXT_CLKS;
  localparam integer STAB_CYC_N = `CCS_OSTAB_CYC;
  localparam integer GAP_CYC_N = `CCS_SW_GAP_CYC;
  localparam [`CCS_CNT_W-1:0] AMP_CYC = AMP_CYC_N[`CCS_CNT_W-1:0];
  localparam [`CCS_CNT_W-1:0] AMP_EXT = AMP_EXT_N[`CCS_CNT_W-1:0];
  localparam [`CCS_CNT_W-1:0] STAB_CYC = STAB_CYC_N[`CCS_CNT_W-1:0];
  localparam [1:0] GAP_CYC = GAP_CYC_N[1:0];

  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  function [2:0] src_of;
    input sub_sel;
    input hs_src;
    input sys_sel;
    begin
      if (sub_sel)
        src_of = `CCS_SRC_SUB;
      else if (hs_src && sys_sel)
        src_of = `CCS_SRC_HIGH;
      else
        src_of = `CCS_SRC_INT;
    end
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg main_ext_q;
  reg main_pin_q;
  reg sub_ext_q;
  reg sub_pin_q;
  reg amp_high_q;
  reg main_halt_q;
  reg hs_src_q;
  reg sys_sel_q;
  reg sub_alt_q;
  reg cpu_sub_q;
  reg int_halt_q;
  reg amp_locked_q;
  reg hs_locked_q;
  reg amp_ext_mode_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] gap_q;
  reg [1:0] gap_d;
  reg [2:0] cur_src_q;
  reg [2:0] cur_src_d;

  wire wr_mode = reg_wr && (reg_addr == `CCS_ADDR_CLK_OP_MODE);
  wire wr_moc = reg_wr && (reg_addr == `CCS_ADDR_MAIN_OSC_CTRL);
  wire wr_mcm = reg_wr && (reg_addr == `CCS_ADDR_MAIN_CLK_MODE);
  wire wr_pcc = reg_wr && (reg_addr == `CCS_ADDR_PROC_CLK_CTRL);
  wire wr_rcm = reg_wr && (reg_addr == `CCS_ADDR_INT_OSC_MODE);

  wire amp_new = reg_wdata[`CCS_BIT_AMP_HIGH];
  wire hs_new = reg_wdata[`CCS_BIT_HS_SRC];
  wire amp_take = wr_mode && !amp_locked_q && (amp_new != amp_high_q); // [RULE5]
  wire hs_take = wr_mcm && !hs_locked_q && (hs_new != hs_src_q); // [RULE5]
  wire amp_rise = amp_take && amp_new;

  wire main_xtal = main_pin_q && !main_ext_q;
  wire main_ext = main_pin_q && main_ext_q;
  wire main_run = main_xtal && !main_halt_q;
  wire sub_xtal = sub_alt_q || (sub_pin_q && !sub_ext_q);
  wire sub_ext = !sub_alt_q && sub_pin_q && sub_ext_q;
  wire int_stat = int_osc_ready && !int_halt_q;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      main_ext_q <= 1'b0;
      main_pin_q <= 1'b0;
      sub_ext_q <= 1'b0;
      sub_pin_q <= 1'b0;
      amp_high_q <= 1'b0;
      main_halt_q <= 1'b1;
      hs_src_q <= 1'b0;
      sys_sel_q <= 1'b0;
      sub_alt_q <= 1'b0;
      cpu_sub_q <= 1'b0;
      int_halt_q <= `CCS_RST_INT_HALT;
      amp_locked_q <= 1'b0;
      hs_locked_q <= 1'b0;
      amp_ext_mode_q <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        main_ext_q <= reg_wdata[`CCS_BIT_MAIN_EXT]; // [RULE13]
        main_pin_q <= reg_wdata[`CCS_BIT_MAIN_PIN]; // [RULE13]
        sub_ext_q <= reg_wdata[`CCS_BIT_SUB_EXT]; // [RULE13]
        sub_pin_q <= reg_wdata[`CCS_BIT_SUB_PIN]; // [RULE13]
      end
      if (amp_take)
      begin
        amp_high_q <= amp_new; // [RULE13]
        amp_locked_q <= 1'b1; // [RULE5]
      end
      if (amp_rise)
        amp_ext_mode_q <= main_ext; // [RULE19]
      if (wr_moc)
        main_halt_q <= reg_wdata[`CCS_BIT_MAIN_HALT]; // [RULE14]
      if (hs_take)
      begin
        hs_src_q <= hs_new; // [RULE15]
        hs_locked_q <= 1'b1; // [RULE5]
      end
      if (wr_mcm)
        sys_sel_q <= reg_wdata[`CCS_BIT_MAIN_SYS]; // [RULE15]
      if (wr_pcc)
      begin
        sub_alt_q <= reg_wdata[`CCS_BIT_SUB_ALT]; // [RULE16]
        cpu_sub_q <= reg_wdata[`CCS_BIT_CPU_SUB]; // [RULE16]
      end
      if (wr_rcm)
        int_halt_q <= reg_wdata[`CCS_BIT_INT_HALT]; // [RULE17]
    end
  end

  // ----------------------------------------
  // Stabilization counter and range hold
  // ----------------------------------------
  wire stab_busy;
  wire hold_busy;
  wire stab_done = main_run && !stab_busy; // [RULE1]
  wire hold_tick = amp_ext_mode_q ? ext_main_tick : 1'b1; // [RULE19]
  wire [`CCS_CNT_W-1:0] hold_val = main_ext ? AMP_EXT : AMP_CYC; // [RULE18]

  ccs_tmr u_stab (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(!main_run), // [RULE1]
    .load_val(STAB_CYC),
    .tick(1'b1),
    .busy(stab_busy)
  );

  ccs_tmr u_hold (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(amp_rise && main_pin_q), // [RULE18]
    .load_val(hold_val),
    .tick(hold_tick),
    .busy(hold_busy)
  );

  // ----------------------------------------
  // Source switch sequencer
  // ----------------------------------------
  wire [2:0] tgt_src = src_of(cpu_sub_q, hs_src_q, sys_sel_q);

  always @*
  begin
    state_d = state_q;
    gap_d = gap_q;
    cur_src_d = cur_src_q;
    case (state_q)
      ST_RUN:
      begin
        if (tgt_src != cur_src_q)
        begin
          state_d = ST_OFF; // [RULE20]
          gap_d = GAP_CYC;
        end
      end
      ST_OFF:
      begin
        if (gap_q != 2'h0)
        begin
          gap_d = gap_q - 2'h1;
          // Move source while gate still shut
          if (gap_q == 2'h1)
            cur_src_d = tgt_src; // [RULE20]
        end
        else
          state_d = ST_ON;
      end
      ST_ON:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RUN;
        gap_d = 2'h0;
        cur_src_d = `CCS_SRC_INT;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_q <= ST_RUN;
      gap_q <= 2'h0;
      cur_src_q <= `CCS_SRC_INT;
    end
    else
    begin
      state_q <= state_d;
      gap_q <= gap_d;
      cur_src_q <= cur_src_d;
    end
  end

  // ----------------------------------------
  // Oscillator and CPU clock outputs
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      main_osc_en <= 1'b0;
      main_ext_en <= 1'b0;
      main_amp_high <= 1'b0;
      sub_osc_en <= 1'b0;
      sub_ext_en <= 1'b0;
      int_osc_en <= 1'b1;
      cpu_src <= `CCS_SRC_INT;
      cpu_clk_en <= 1'b1;
    end
    else
    begin
      main_osc_en <= main_run;
      main_ext_en <= main_ext && !main_halt_q;
      main_amp_high <= amp_high_q;
      sub_osc_en <= sub_xtal;
      sub_ext_en <= sub_ext;
      int_osc_en <= !int_halt_q;
      cpu_src <= cur_src_d;
      cpu_clk_en <= (state_d != ST_OFF) && !hold_busy; // [RULE18] [RULE20]
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `CCS_ADDR_CLK_OP_MODE:
          reg_rdata <= {main_ext_q, main_pin_q, sub_ext_q, sub_pin_q, 3'h0, amp_high_q};
        `CCS_ADDR_MAIN_OSC_CTRL:
          reg_rdata <= {main_halt_q, 7'h00};
        `CCS_ADDR_MAIN_CLK_MODE:
          reg_rdata <= {5'h00, hs_src_q, 1'b0, sys_sel_q};
        `CCS_ADDR_PROC_CLK_CTRL:
          reg_rdata <= {1'b0, sub_alt_q, 1'b0, cpu_sub_q, 4'h0};
        `CCS_ADDR_INT_OSC_MODE:
          reg_rdata <= {int_stat, 6'h00, int_halt_q}; // [RULE17] [RULE10]
        `CCS_ADDR_OSC_STAB:
          reg_rdata <= {6'h00, sub_osc_ready, stab_done}; // [RULE1] [RULE7]
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // ccs_switch

// ### hw/ccs_tmr.v
`timescale 1ns/1ps
// ----------------------------------------
// Loadable down counter
// ----------------------------------------
`include "ccs_map.vh"
module ccs_tmr (
  input wire clk_sys,                  // System clock
  input wire nrst,                     // Sync reset, active low
  input wire load,                     // Load count
  input wire [`CCS_CNT_W-1:0] load_val, // Count to load
  input wire tick,                     // Count one step
  output wire busy                     // Count not yet zero
);
  reg [`CCS_CNT_W-1:0] cnt_q;
  assign busy = (cnt_q != {`CCS_CNT_W{1'b0}});
  always @(posedge clk_sys)
  begin
    if (!nrst)
      cnt_q <= {`CCS_CNT_W{1'b0}};
    else if (load)
      cnt_q <= load_val;
    else if (tick && busy)
      cnt_q <= cnt_q - {{(`CCS_CNT_W-1){1'b0}}, 1'b1};
  end
endmodule // ccs_tmr

// ### sim/ccs_switch_assertions.sv
`timescale 1ns/1ps
module ccs_switch_assertions (
  input wire clk_sys, // System clock
  input wire nrst, // Sync reset, active low
  input wire [2:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_rdata, // Read data
  input wire main_osc_en, // Main crystal on
  input wire main_ext_en, // Main external on
  input wire main_amp_high, // High range
  input wire sub_osc_en, // Sub crystal on
  input wire sub_ext_en, // Sub external on
  input wire int_osc_en, // Internal oscillator on
  input wire [2:0] cpu_src, // CPU source
  input wire cpu_clk_en // CPU clock gate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Gate-low run length and range history
  // ----------------------------------------
  reg [10:0] low_q;
  reg amp_seen_q;
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      low_q <= 11'h000;
      amp_seen_q <= 1'b0;
    end
    else
    begin
      low_q <= cpu_clk_en ? 11'h000 : low_q + 11'h001;
      if ($changed(main_amp_high))
        amp_seen_q <= 1'b1;
    end
  end
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rd_unmap;
    reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_int_on;
    reg_wr && reg_addr == 3'h4 && !reg_wdata[0] |-> ##[1:2] int_osc_en;
  endproperty
  a_int_on: assert property (p_int_on) else $error("internal osc not restarted");
  property p_gate_len;
    $fell(cpu_clk_en) |-> !cpu_clk_en [*3];
  endproperty
  a_gate_len: assert property (p_gate_len) else $error("gate low too short");
  property p_src_gated;
    $changed(cpu_src) |-> !cpu_clk_en && !$past(cpu_clk_en);
  endproperty
  a_src_gated: assert property (p_src_gated) else $error("source moved with gate open");
  property p_src_late;
    $changed(cpu_src) |-> $past(cpu_clk_en, 3) && !$past(cpu_clk_en, 2);
  endproperty
  a_src_late: assert property (p_src_late) else $error("source moved off slot");
  property p_to_sub;
    reg_wr && reg_addr == 3'h3 && reg_wdata[4] && cpu_src == 3'h1 && cpu_clk_en
      |=> ##1 !cpu_clk_en [*3] ##1 (cpu_clk_en && cpu_src == 3'h4);
  endproperty
  a_to_sub: assert property (p_to_sub) else $error("sub switch sequence wrong");
  property p_hold_max;
    low_q <= 11'h3F7;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("gate held low too long");
  property p_amp_once;
    amp_seen_q |-> $stable(main_amp_high);
  endproperty
  a_amp_once: assert property (p_amp_once) else $error("range changed twice");
  property p_excl;
    !(main_osc_en && main_ext_en) && !(sub_osc_en && sub_ext_en) && $onehot(cpu_src);
  endproperty
  a_excl: assert property (p_excl) else $error("exclusive outputs clash");
  c_sub: cover property ($changed(cpu_src) && cpu_src == 3'h4);
  c_hold: cover property (low_q == 11'h3F7);
  c_amp: cover property ($rose(main_amp_high));
endmodule // ccs_switch_assertions
bind ccs_switch ccs_switch_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .main_osc_en(main_osc_en), .main_ext_en(main_ext_en),
  .main_amp_high(main_amp_high), .sub_osc_en(sub_osc_en), .sub_ext_en(sub_ext_en),
  .int_osc_en(int_osc_en), .cpu_src(cpu_src), .cpu_clk_en(cpu_clk_en));

// ### sim/ccs_switch_test.sv
`timescale 1ns/1ps
module ccs_switch_test;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg int_osc_ready = 1'b1;
  reg sub_osc_ready = 1'b0;
  reg ext_main_tick = 1'b0;
  reg tick_on = 1'b0;
  wire [7:0] reg_rdata;
  wire [2:0] cpu_src;
  wire main_osc_en, main_ext_en, main_amp_high, sub_osc_en, sub_ext_en;
  wire int_osc_en, cpu_clk_en;
  integer num_errors = 0;
  integer num_checks = 0;
  reg [15:0] n, t;
  reg [7:0] v;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ext_main_tick <= tick_on & ~ext_main_tick;
  ccs_switch dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_osc_ready(int_osc_ready), .sub_osc_ready(sub_osc_ready),
    .ext_main_tick(ext_main_tick), .main_osc_en(main_osc_en), .main_ext_en(main_ext_en),
    .main_amp_high(main_amp_high), .sub_osc_en(sub_osc_en), .sub_ext_en(sub_ext_en),
    .int_osc_en(int_osc_en), .cpu_src(cpu_src), .cpu_clk_en(cpu_clk_en));
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task expire;
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      wrap_up;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rst;
    begin
      nrst <= 1'b0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task rc(input [2:0] a, input [7:0] exp);
    begin
      rd(a, v);
      check(v, exp);
    end
  endtask
  // Write that moves the CPU source, then the gate slot
  task sw(input [2:0] a, input [7:0] d, input [2:0] src);
    begin
      wr(a, d);
      repeat (3)
      begin
        @(posedge clk_sys);
        #1 check(cpu_clk_en, 1'b0);
      end
      check(cpu_src, src);
      @(posedge clk_sys);
      #1 check(cpu_clk_en, 1'b1);
    end
  endtask
  // Counts gate-low cycles and tick pulses after a write
  task hold(output [15:0] cnt, output [15:0] ticks);
    begin
      cnt = 0;
      ticks = 0;
      @(posedge clk_sys);
      #1;
      while (cpu_clk_en !== 1'b1 && cnt < 16'h07D0)
      begin
        cnt = cnt + 1;
        ticks = ticks + ext_main_tick;
        @(posedge clk_sys);
        #1;
      end
      if (cnt == 16'h07D0)
        expire;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    expire;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    rst;
    check({int_osc_en, cpu_src, cpu_clk_en}, 5'h13);
    rc(3'h0, 8'h00);
    rc(3'h1, 8'h80);
    rc(3'h2, 8'h00);
    rc(3'h3, 8'h00);
    rc(3'h4, 8'h80);
    rc(3'h5, 8'h00);
    rc(3'h6, 8'h00);
    $display("Test reset values done");
    wr(3'h0, 8'hF0);
    wr(3'h1, 8'h00);
    rc(3'h0, 8'hF0);
    rc(3'h1, 8'h00);
    check({main_ext_en, main_osc_en, sub_ext_en, sub_osc_en}, 4'hA);
    wr(3'h3, 8'h40);
    rc(3'h3, 8'h40);
    check({sub_ext_en, sub_osc_en}, 2'h1);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h01);
    rc(3'h4, 8'h01);
    check(int_osc_en, 1'b0);
    wr(3'h4, 8'h00);
    @(posedge clk_sys);
    int_osc_ready <= 1'b0;
    rc(3'h4, 8'h00);
    @(posedge clk_sys);
    int_osc_ready <= 1'b1;
    rc(3'h4, 8'h80);
    $display("Test register fields done");
    tick_on <= 1'b1;
    wr(3'h0, 8'hF1);
    hold(n, t);
    check(t >= 16'h009F && t <= 16'h00A1, 1'b1);
    check(main_amp_high, 1'b1);
    tick_on <= 1'b0;
    wr(3'h0, 8'hF0);
    rc(3'h0, 8'hF1);
    sw(3'h2, 8'h05, 3'h2);
    wr(3'h2, 8'h01);
    rc(3'h2, 8'h05);
    check(cpu_src, 3'h2);
    sw(3'h2, 8'h04, 3'h1);
    $display("Test external main done");
    @(posedge clk_sys);
    sub_osc_ready <= 1'b1;
    rc(3'h5, 8'h02);
    sw(3'h3, 8'h10, 3'h4);
    wr(3'h3, 8'h10);
    rc(3'h3, 8'h10);
    check({cpu_src, cpu_clk_en}, 4'h9);
    rc(3'h4, 8'h80);
    sw(3'h3, 8'h00, 3'h1);
    wr(3'h2, 8'h04);
    rc(3'h2, 8'h04);
    check({cpu_src, cpu_clk_en}, 4'h3);
    $display("Test subsystem done");
    rst;
    wr(3'h0, 8'h40);
    wr(3'h1, 8'h00);
    rc(3'h5, 8'h02);
    check(main_osc_en, 1'b1);
    n = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && n < 16'h0258)
    begin
      rd(3'h5, v);
      n = n + 1;
    end
    if (n == 16'h0258)
      expire;
    check(n > 16'h012C, 1'b1);
    wr(3'h0, 8'h41);
    hold(n, t);
    check(n, 16'h03F7);
    check(main_amp_high, 1'b1);
    sw(3'h2, 8'h05, 3'h2);
    $display("Test main crystal done");
    wrap_up;
  end
endmodule // ccs_switch_test
